/* rtl/pfs_consts.vh */
// pfs_consts.vh: register offsets, field positions, reset values and timing counts
// assumes a 125 MHz clock and 32-bit classic wishbone register access
`ifndef PFS_CONSTS_VH
`define PFS_CONSTS_VH
// ==========================================================================
// register byte offsets
`define PFS_REG_CTRL 8'h00
`define PFS_REG_UVTH 8'h04
`define PFS_REG_OVTH 8'h08
`define PFS_REG_OTTH 8'h0C
`define PFS_REG_POL 8'h10
`define PFS_REG_STAT 8'h14
`define PFS_REG_TGT 8'h18
`define PFS_REG_RAMP 8'h1C
// ==========================================================================
// fault policy codes, 3 bits per source in the policy register
`define PFS_POL_IMM 3'h0
`define PFS_POL_CONT 3'h1
`define PFS_POL_DLYOFF 3'h2
`define PFS_POL_RETRY_INF 3'h3
`define PFS_POL_RETRY_N 3'h4
`define PFS_POL_LOWON 3'h5
// field positions in the policy register
`define PFS_POL_UV_LSB 0
`define PFS_POL_OV_LSB 4
`define PFS_POL_OC_LSB 8
`define PFS_POL_OT_LSB 12
`define PFS_POL_RCNT_LSB 16
// ==========================================================================
// reset values; thresholds in millivolts, percent and degrees
`define PFS_UV_LOW_MV 16'h0BB8
`define PFS_UV_OPEN_MV 16'h1194
`define PFS_UV_HIGH_MV 16'h2A30
`define PFS_UV_MIN_MV 16'h0B22
`define PFS_UV_MAX_MV 16'h3E80
`define PFS_OV_PCT 8'h0F
`define PFS_OT_DEF_C 8'h7D
`define PFS_OT_HYST_C 8'h0F
`define PFS_TGT_DEF_MV 16'h04B0
`define PFS_RAMP_DEF 16'h0064
`define PFS_POL_DEF 32'h0003_0000
// ==========================================================================
// timing: delay time in microseconds, cycles derived at 125 MHz
`define PFS_CLK_MHZ 125
`define PFS_DLY_US 1000
`define PFS_DLY_CYC (`PFS_DLY_US * `PFS_CLK_MHZ)
`endif

/* rtl/pfs_power_fault_supervisor.v */
// pfs_power_fault_supervisor.v: fault supervision and start-up control of a buck regulator
// assumes synchronous comparator flags and measurements are synchronised here from pins,
// and a classic wishbone master on the same clock
//
// The address map and register access over Wishbone are this design's own decisions.
`timescale 1ns/100ps
`include "pfs_consts.vh"

module pfs_power_fault_supervisor #(
  parameter DLY_CYC = `PFS_DLY_CYC,
  parameter RAMP_UNIT = 125
) (
  input wire clk_i,
  input wire rst_i,
  input wire [1:0] strap_level_i,
  input wire strap_res_i,
  input wire [4:0] strap_index_i,
  input wire [15:0] vin_mv_i,
  input wire [15:0] output_sense_input_i,
  input wire oc_flag_i,
  input wire [7:0] temp_c_i,
  input wire en_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg hs_en_o,
  output reg ls_en_o,
  output reg output_good_flag_o,
  output reg [15:0] vref_mv_o
);

  // ==========================================================================
  // state codes, one-hot
  localparam S_OFF = 5'h01;
  localparam S_DLY = 5'h02;
  localparam S_RAMP = 5'h04;
  localparam S_RUN = 5'h08;
  localparam S_FLT = 5'h10;

  // resistor strap table, nineteen entries in millivolts
  function [15:0] res_thresh;
    input [4:0] idx;
    begin
      case (idx)
        5'h00: res_thresh = 16'h0B22;
        5'h01: res_thresh = 16'h0C44;
        5'h02: res_thresh = 16'h0D70;
        5'h03: res_thresh = 16'h0ECE;
        5'h04: res_thresh = 16'h1054;
        5'h05: res_thresh = 16'h11EE;
        5'h06: res_thresh = 16'h13C4;
        5'h07: res_thresh = 16'h15C2;
        5'h08: res_thresh = 16'h17F2;
        5'h09: res_thresh = 16'h1A5E;
        5'h0A: res_thresh = 16'h1CFC;
        5'h0B: res_thresh = 16'h1FF4;
        5'h0C: res_thresh = 16'h231E;
        5'h0D: res_thresh = 16'h26AC;
        5'h0E: res_thresh = 16'h2A94;
        5'h0F: res_thresh = 16'h2EE0;
        5'h10: res_thresh = 16'h3390;
        5'h11: res_thresh = 16'h38CC;
        default: res_thresh = 16'h3E80;
      endcase
    end
  endfunction

  // ==========================================================================
  // two-flop synchronisers for every strap, measurement, flag and enable input; reset and bus inputs are used directly
  reg [1:0] lvl_m_reg, lvl_reg;
  reg res_m_reg, res_reg, oc_m_reg, oc_reg, en_m_reg, en_reg;
  reg [4:0] idx_m_reg, idx_reg;
  reg [15:0] vin_m_reg, vin_reg, vs_m_reg, vs_reg;
  reg [7:0] tc_m_reg, tc_reg;

  // first stage feeds only the second stage
  always @(posedge clk_i) begin
    lvl_m_reg <= strap_level_i;
    lvl_reg <= lvl_m_reg;
    res_m_reg <= strap_res_i;
    res_reg <= res_m_reg;
    idx_m_reg <= strap_index_i;
    idx_reg <= idx_m_reg;
    vin_m_reg <= vin_mv_i;
    vin_reg <= vin_m_reg;
    vs_m_reg <= output_sense_input_i;
    vs_reg <= vs_m_reg;
    oc_m_reg <= oc_flag_i;
    oc_reg <= oc_m_reg;
    tc_m_reg <= temp_c_i;
    tc_reg <= tc_m_reg;
    en_m_reg <= en_i;
    en_reg <= en_m_reg;
  end

  // ==========================================================================
  // registers
  reg [31:0] ctrl_reg, pol_reg;
  reg [15:0] uvth_reg, tgt_reg, ramp_reg;
  reg [7:0] ovpct_reg, otth_reg;
  reg [3:0] stat_reg;
  reg [15:0] strap_th_reg;
  reg strap_done_reg;

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr = bus_req & wb_we_i & (&wb_sel_i);
  wire [7:0] badr = wb_adr_i[7:0];

  // strap captured once after reset release, never under reset itself
  always @(posedge clk_i) begin
    if (rst_i) begin
      strap_done_reg <= 1'b0;
      strap_th_reg <= `PFS_UV_OPEN_MV;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'b1;
      if (res_reg)
        strap_th_reg <= res_thresh(idx_reg);
      else if (lvl_reg == 2'b00)
        strap_th_reg <= `PFS_UV_LOW_MV;
      else if (lvl_reg == 2'b11)
        strap_th_reg <= `PFS_UV_HIGH_MV;
      else
        strap_th_reg <= `PFS_UV_OPEN_MV;
    end
  end

  // bus-written threshold, clamped into range, wins once ctrl bit 1 is set
  wire [15:0] uv_clamp = (wb_dat_i[15:0] < `PFS_UV_MIN_MV) ? `PFS_UV_MIN_MV :
    (wb_dat_i[15:0] > `PFS_UV_MAX_MV) ? `PFS_UV_MAX_MV : wb_dat_i[15:0];
  wire [15:0] uv_th = ctrl_reg[1] ? uvth_reg : strap_th_reg;

  // ==========================================================================
  // fault detection
  wire [23:0] ov_prod = tgt_reg * (8'h64 + ovpct_reg);
  wire [23:0] ov_quo = ov_prod / 24'h64;
  // saturate rather than wrap when target and percent overflow 16 bits, while the product still fits 24 bits
  wire [15:0] ov_lim = (ov_quo > 24'h00FFFF) ? 16'hFFFF : ov_quo[15:0];
  wire uv_now = vin_reg < uv_th;
  wire ov_now = vs_reg > ov_lim;
  wire ot_now = tc_reg > otth_reg;
  wire ot_cool = tc_reg < (otth_reg - `PFS_OT_HYST_C);
  wire [3:0] now = {ot_now, oc_reg, ov_now, uv_now};
  wire [3:0] relief = {ot_cool, ~oc_reg, ~ov_now, ~uv_now};

  reg [4:0] st_reg;
  reg [3:0] trip_reg, latch_reg, arm_reg, lowon_reg;
  wire [3:0] kill;

  // ==========================================================================
  // per-source policy engine: delay timer, retry counter, trip decision
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : src
      reg [31:0] tmr_reg;
      reg [3:0] cnt_reg;
      wire [2:0] pol = pol_reg[4*g +: 3];
      wire tmo = (tmr_reg == DLY_CYC - 1);
      // immediate or retry policies trip at once; delayed off trips at timeout
      assign kill[g] = now[g] & (pol != `PFS_POL_CONT) &
        ((pol != `PFS_POL_DLYOFF) | tmo);
      always @(posedge clk_i) begin
        if (rst_i) begin
          tmr_reg <= 32'h0;
          cnt_reg <= 4'h0;
          trip_reg[g] <= 1'b0;
          latch_reg[g] <= 1'b0;
          lowon_reg[g] <= 1'b0;
        end else if (!trip_reg[g]) begin
          // delayed-off timer runs while fault persists, in any state including off
          tmr_reg <= (now[g] && !tmo) ? tmr_reg + 32'h1 : 32'h0;
          if (kill[g] && st_reg != S_OFF) begin
            trip_reg[g] <= 1'b1;
            tmr_reg <= 32'h0;
            lowon_reg[g] <= (g == 1) && (pol == `PFS_POL_LOWON);
            // delayed-off stays down until re-enabled
            latch_reg[g] <= (pol == `PFS_POL_DLYOFF) ||
              ((pol == `PFS_POL_RETRY_N) &&
              (cnt_reg == pol_reg[`PFS_POL_RCNT_LSB +: 4]));
            if (pol == `PFS_POL_RETRY_N)
              cnt_reg <= cnt_reg + 4'h1;
          end else if (st_reg == S_RUN && !now[g])
            cnt_reg <= 4'h0;
        end else if (latch_reg[g]) begin
          // exhausted or delayed-off: wait for enable to drop
          if (!en_reg) begin
            trip_reg[g] <= 1'b0;
            latch_reg[g] <= 1'b0;
            lowon_reg[g] <= 1'b0;
            cnt_reg <= 4'h0;
          end
        end else if (pol == `PFS_POL_IMM || pol == `PFS_POL_CONT) begin
          // continuous check, re-enable once clear
          if (relief[g]) begin
            trip_reg[g] <= 1'b0;
            lowon_reg[g] <= 1'b0;
          end
        end else if (tmo) begin
          // retry after preset delay; temperature waits below warning
          // other sources attempt the restart, which spends a retry if still faulty
          tmr_reg <= 32'h0;
          if (relief[g] || g != 3) begin
            trip_reg[g] <= 1'b0;
            lowon_reg[g] <= 1'b0;
          end
        end else
          tmr_reg <= tmr_reg + 32'h1;
      end
    end
  endgenerate

  // ==========================================================================
  // start-up sequencer with pre-bias handling
  reg [31:0] seq_tmr_reg;
  reg [15:0] step_reg;
  reg [15:0] ramp_left_reg;
  wire seq_tmo = (seq_tmr_reg == DLY_CYC - 1);
  wire tick = (seq_tmr_reg[15:0] == RAMP_UNIT - 1);
  wire any_trip = |trip_reg;
  wire [15:0] gap = (vs_reg > tgt_reg) ? vs_reg - tgt_reg : tgt_reg - vs_reg;
  wire [15:0] rdiv = (ramp_reg == 16'h0) ? 16'h1 : ramp_reg;

  // sequencer: off, delay, ramp, run, fault
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= S_OFF;
      seq_tmr_reg <= 32'h0;
      step_reg <= 16'h0;
      ramp_left_reg <= 16'h0;
      vref_mv_o <= 16'h0;
      hs_en_o <= 1'b0;
      ls_en_o <= 1'b0;
      output_good_flag_o <= 1'b0;
    end else begin
      case (st_reg)
        S_OFF: begin
          hs_en_o <= 1'b0;
          ls_en_o <= 1'b0;
          output_good_flag_o <= 1'b0;
          seq_tmr_reg <= 32'h0;
          if (en_reg && ctrl_reg[0] && !any_trip)
            st_reg <= S_DLY;
        end
        S_DLY: begin
          seq_tmr_reg <= seq_tmr_reg + 32'h1;
          if (!en_reg || any_trip)
            st_reg <= any_trip ? S_FLT : S_OFF;
          else if (seq_tmr_reg[15:0] == 16'h0 && ov_now) // pre-bias check
            st_reg <= S_FLT; // fault state entered whatever the overvoltage policy
          else if (seq_tmr_reg >= DLY_CYC - 1) begin
            // start from the sensed level, both drivers on
            vref_mv_o <= vs_reg;
            hs_en_o <= 1'b1;
            ls_en_o <= 1'b1;
            step_reg <= gap / rdiv + 16'h1;
            ramp_left_reg <= ramp_reg;
            seq_tmr_reg <= 32'h0;
            st_reg <= S_RAMP;
          end
        end
        S_RAMP: begin
          // same ramp time whatever the pre-bias: step scales with gap
          seq_tmr_reg <= tick ? 32'h0 : seq_tmr_reg + 32'h1;
          if (any_trip)
            st_reg <= S_FLT;
          else if (tick) begin
            if (ramp_left_reg == 16'h0) begin
              // an above-target start keeps its level; run ramps it down
              if (vref_mv_o < tgt_reg)
                vref_mv_o <= tgt_reg;
              output_good_flag_o <= 1'b1; // good when ramp period ends
              st_reg <= S_RUN;
            end else begin
              ramp_left_reg <= ramp_left_reg - 16'h1;
              if (vref_mv_o < tgt_reg)
                vref_mv_o <= (tgt_reg - vref_mv_o < step_reg) ? tgt_reg :
                  vref_mv_o + step_reg;
            end
          end
        end
        S_RUN: begin
          // above-target pre-bias ramps down after good is raised
          if (vref_mv_o > tgt_reg)
            vref_mv_o <= vref_mv_o - 16'h1;
          else
            vref_mv_o <= tgt_reg;
          output_good_flag_o <= ~ov_now; // dropped at once
          if (any_trip)
            st_reg <= S_FLT;
          else if (!en_reg || !ctrl_reg[0])
            st_reg <= S_OFF;
        end
        S_FLT: begin
          hs_en_o <= 1'b0;
          ls_en_o <= |lowon_reg; // low side held until restart
          output_good_flag_o <= 1'b0;
          seq_tmr_reg <= 32'h0;
          if (!any_trip)
            st_reg <= S_OFF;
        end
        default: st_reg <= S_OFF;
      endcase
    end
  end

  // ==========================================================================
  // sticky status: set wins over write-one-to-clear
  wire [3:0] stat_set = now & kill | (st_reg == S_DLY && ov_now ? 4'h2 : 4'h0);
  wire stat_clr = bus_wr && badr == `PFS_REG_STAT;
  always @(posedge clk_i) begin
    if (rst_i)
      stat_reg <= 4'h0;
    else
      stat_reg <= (stat_reg & ~(stat_clr ? wb_dat_i[3:0] : 4'h0)) | stat_set;
  end

  // ==========================================================================
  // wishbone slave: one wait, ack one cycle, full-word writes only
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl_reg <= 32'h1;
      uvth_reg <= `PFS_UV_OPEN_MV;
      ovpct_reg <= `PFS_OV_PCT;
      otth_reg <= `PFS_OT_DEF_C;
      pol_reg <= `PFS_POL_DEF; // all sources immediate
      tgt_reg <= `PFS_TGT_DEF_MV;
      ramp_reg <= `PFS_RAMP_DEF;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_wr) begin
        case (badr)
          `PFS_REG_CTRL: ctrl_reg <= {30'h0, wb_dat_i[1:0]};
          `PFS_REG_UVTH: uvth_reg <= uv_clamp;
          `PFS_REG_OVTH: ovpct_reg <= wb_dat_i[7:0];
          `PFS_REG_OTTH: otth_reg <= wb_dat_i[7:0];
          `PFS_REG_POL: pol_reg <= wb_dat_i & 32'h000F_7777;
          `PFS_REG_TGT: tgt_reg <= wb_dat_i[15:0];
          `PFS_REG_RAMP: ramp_reg <= wb_dat_i[15:0];
          default: ;
        endcase
      end
      case (badr)
        `PFS_REG_CTRL: wb_dat_o <= ctrl_reg;
        `PFS_REG_UVTH: wb_dat_o <= {16'h0, uv_th};
        `PFS_REG_OVTH: wb_dat_o <= {24'h0, ovpct_reg};
        `PFS_REG_OTTH: wb_dat_o <= {24'h0, otth_reg};
        `PFS_REG_POL: wb_dat_o <= pol_reg;
        `PFS_REG_STAT: wb_dat_o <= {19'h0, st_reg, trip_reg, stat_reg};
        `PFS_REG_TGT: wb_dat_o <= {16'h0, tgt_reg};
        `PFS_REG_RAMP: wb_dat_o <= {16'h0, ramp_reg};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

endmodule

/* sim/pfs_plant_model.sv */
// pfs_plant_model.sv: output stage as seen by the supervisor's sense input
// assumes the bench sets the pre-bias level and an overvoltage force level
`timescale 1ns/100ps

module pfs_plant_model (
  input wire logic hs_en_i,
  input wire logic ls_en_i,
  input wire logic [15:0] vref_mv_i,
  input wire logic [15:0] prebias_mv_i,
  input wire logic [15:0] force_mv_i,
  output logic [15:0] sense_mv_o
);
  // ==========================================================================
  // sense level
  // a switching stage follows the reference; a low-side clamp pulls the
  // output to ground; an idle stage keeps the external pre-bias
  assign sense_mv_o = (force_mv_i != 16'h0000) ? force_mv_i :
    hs_en_i ? vref_mv_i : ls_en_i ? 16'h0000 : prebias_mv_i;
endmodule

/* sim/pfs_power_fault_supervisor_sva.sv */
// pfs_power_fault_supervisor_sva.sv: port checker of the fault supervisor
// assumes the temperature limit and overvoltage percent keep their reset values
`timescale 1ns/100ps
`include "pfs_consts.vh"

module pfs_fault_sva #(
  parameter DLY_CYC = 20,
  parameter RAMP_UNIT = 4
) (
  input wire clk_i,
  input wire rst_i,
  input wire [15:0] vin_mv_i,
  input wire [15:0] output_sense_input_i,
  input wire oc_flag_i,
  input wire [7:0] temp_c_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0] wb_sel_i,
  input wire wb_we_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire hs_en_o,
  input wire ls_en_o,
  input wire output_good_flag_o,
  input wire [15:0] vref_mv_o
);
  reg [31:0] pol_reg;
  wire ov_c;
  // ==========================================================================
  // policy shadow from completed writes, so each check follows the mode
  always @(posedge clk_i) begin
    if (rst_i) begin
      pol_reg <= `PFS_POL_DEF;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i == 4'hF &&
                 wb_adr_i[7:0] == `PFS_REG_POL) begin
      pol_reg <= wb_dat_i;
    end
  end
  // zero reference means an idle stage, where no overvoltage is judged
  assign ov_c = (vref_mv_o != 16'h0000) &&
    ({16'h0000, output_sense_input_i} * 32'd100 > {16'h0000, vref_mv_o} * 32'd115);
  // ==========================================================================
  // properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ov;
    ov_c [*6];
  endsequence
  a_ack_follows: assert property (s_req |=> wb_ack_o)
    else $error("no ack after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_ov_good: assert property (s_ov |-> !output_good_flag_o)
    else $error("good held over overvoltage");
  // the policy must stand over the whole window, since a mid-fault switch restarts it
  a_ov_off: assert property ((ov_c && pol_reg[6:4] == `PFS_POL_IMM) [*6] |-> !hs_en_o)
    else $error("high side on over overvoltage");
  a_ov_clamp: assert property ((ov_c && pol_reg[6:4] == `PFS_POL_LOWON) [*6] |->
    ls_en_o && !hs_en_o)
    else $error("low-side clamp missing");
  a_oc_off: assert property ((oc_flag_i && pol_reg[10:8] == `PFS_POL_IMM) [*6] |->
    !hs_en_o)
    else $error("high side on over overcurrent");
  a_uv_off: assert property ((vin_mv_i < `PFS_UV_MIN_MV && pol_reg[2:0] == `PFS_POL_IMM) [*6]
    |-> !hs_en_o)
    else $error("high side on in lockout");
  a_ot_off: assert property ((temp_c_i > `PFS_OT_DEF_C && pol_reg[14:12] == `PFS_POL_IMM) [*6]
    |-> !hs_en_o)
    else $error("high side on over temperature");
  a_good_drive: assert property (output_good_flag_o |-> hs_en_o)
    else $error("good without drive");
endmodule

bind pfs_power_fault_supervisor pfs_fault_sva #(.DLY_CYC(DLY_CYC), .RAMP_UNIT(RAMP_UNIT)) u_sva (
  .clk_i, .rst_i, .vin_mv_i, .output_sense_input_i, .oc_flag_i, .temp_c_i, .wb_adr_i,
  .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .hs_en_o, .ls_en_o,
  .output_good_flag_o, .vref_mv_o);

/* sim/pfs_power_fault_supervisor_bench.sv */
// pfs_power_fault_supervisor_bench.sv: self-checking bench of the fault supervisor
// assumes the plant model on the sense input and the checker bound to the design
`timescale 1ns/100ps
`include "pfs_consts.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end

module pfs_power_fault_supervisor_bench;
  logic clk_i = 1'b0, rst_i = 1'b1, strap_res_i = 1'b0, oc_flag_i = 1'b0, en_i = 1'b0;
  logic [1:0] strap_level_i = 2'h1;
  logic [4:0] strap_index_i = 5'h00;
  logic [15:0] vin_mv_i = 16'h2EE0, prebias = 16'h0000, force_mv = 16'h0000;
  logic [7:0] temp_c_i = 8'h32;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, q;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, hs_en_o, ls_en_o, output_good_flag_o;
  wire [15:0] vref_mv_o, sense;
  int n_errors = 0, num_checks = 0, cyc = 0, t0, t1;
  // short delay and ramp unit keep each start-up under a hundred cycles
  pfs_power_fault_supervisor #(.DLY_CYC(20), .RAMP_UNIT(4)) u_pfs_power_fault_supervisor (
    .clk_i, .rst_i, .strap_level_i, .strap_res_i, .strap_index_i, .vin_mv_i,
    .output_sense_input_i(sense), .oc_flag_i, .temp_c_i, .en_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .hs_en_o, .ls_en_o,
    .output_good_flag_o, .vref_mv_o);
  pfs_plant_model u_pfs_plant_model (.hs_en_i(hs_en_o), .ls_en_i(ls_en_o), .vref_mv_i(vref_mv_o),
    .prebias_mv_i(prebias), .force_mv_i(force_mv), .sense_mv_o(sense));
  // ==========================================================================
  // clock and hang guard
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      $display("[FAIL] %0t run too long", $time);
      print_verdict;
    end
  end
  // ==========================================================================
  // bus and wait tasks; the request stays put until ack is seen
  task automatic wbx(input logic we, input [7:0] a, input [31:0] d);
    @(posedge clk_i);
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= d;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [31:0] e);
    wbx(1'b0, a, 32'h0);
    `CHK(q, e)
  endtask
  task automatic wg(input logic v);
    t1 = 0;
    while (output_good_flag_o !== v && t1 < 3000) begin
      @(posedge clk_i);
      t1++;
    end
    `CHK(output_good_flag_o, v)
  endtask
  task automatic do_rst(input [1:0] lv, input logic r, input [4:0] ix, input [31:0] e);
    @(posedge clk_i);
    strap_level_i <= lv;
    strap_res_i <= r;
    strap_index_i <= ix;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`PFS_REG_UVTH, e);
  endtask
  task automatic cycle_en;
    @(posedge clk_i) en_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    en_i <= 1'b1;
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ==========================================================================
  // tests
  initial begin
    do_rst(2'h1, 1'b0, 5'h00, 32'h1194);
    rd(`PFS_REG_OVTH, 32'hF);
    rd(`PFS_REG_OTTH, 32'h7D);
    rd(`PFS_REG_POL, 32'h0003_0000);
    rd(8'h40, 32'h0);
    do_rst(2'h0, 1'b0, 5'h00, 32'h0BB8);
    do_rst(2'h3, 1'b0, 5'h00, 32'h2A30);
    do_rst(2'h1, 1'b1, 5'h00, 32'h0B22);
    do_rst(2'h1, 1'b1, 5'h12, 32'h3E80);
    wbx(1'b1, `PFS_REG_CTRL, 32'h3);
    wbx(1'b1, `PFS_REG_UVTH, 32'h64);
    rd(`PFS_REG_UVTH, 32'h0B22);
    wbx(1'b1, `PFS_REG_UVTH, 32'h1194);
    rd(`PFS_REG_UVTH, 32'h1194);
    $display("test straps done");
    // start-up time must not depend on the pre-bias level
    wbx(1'b1, `PFS_REG_RAMP, 32'hA);
    @(posedge clk_i) en_i <= 1'b1;
    wg(1'b1);
    t0 = t1;
    `CHK(vref_mv_o, 16'h04B0)
    @(posedge clk_i) prebias <= 16'h0258;
    cycle_en;
    wg(1'b1);
    `CHK(t1, t0)
    @(posedge clk_i) prebias <= 16'h0514;
    cycle_en;
    wg(1'b1);
    repeat (100) @(posedge clk_i);
    `CHK(vref_mv_o, 16'h04B0)
    @(posedge clk_i) prebias <= 16'h07D0;
    cycle_en;
    repeat (200) @(posedge clk_i);
    `CHK(hs_en_o, 1'b0)
    wbx(1'b0, `PFS_REG_STAT, 32'h0);
    `CHK(q[1], 1'b1)
    @(posedge clk_i) prebias <= 16'h0000;
    wg(1'b1);
    wbx(1'b1, `PFS_REG_STAT, 32'hF);
    wbx(1'b0, `PFS_REG_STAT, 32'h0);
    `CHK(q[3:0], 4'h0)
    $display("test start-up done");
    // overvoltage: shutdown then low-side clamp
    @(posedge clk_i) force_mv <= 16'h05DC;
    wg(1'b0);
    @(posedge clk_i) force_mv <= 16'h0000;
    wg(1'b1);
    wbx(1'b1, `PFS_REG_POL, 32'h0003_0050);
    @(posedge clk_i) force_mv <= 16'h05DC;
    repeat (10) @(posedge clk_i);
    `CHK({hs_en_o, ls_en_o}, 2'b01)
    @(posedge clk_i) force_mv <= 16'h0000;
    wg(1'b1);
    // overcurrent: run on, immediate, counted retries, delayed off, endless
    wbx(1'b1, `PFS_REG_POL, 32'h0003_0100);
    @(posedge clk_i) oc_flag_i <= 1'b1;
    repeat (30) @(posedge clk_i);
    `CHK(hs_en_o, 1'b1)
    wbx(1'b1, `PFS_REG_POL, 32'h0003_0000);
    repeat (10) @(posedge clk_i);
    `CHK(hs_en_o, 1'b0)
    @(posedge clk_i) oc_flag_i <= 1'b0;
    wg(1'b1);
    wbx(1'b1, `PFS_REG_POL, 32'h0001_0400);
    @(posedge clk_i) oc_flag_i <= 1'b1;
    repeat (300) @(posedge clk_i);
    @(posedge clk_i) oc_flag_i <= 1'b0;
    repeat (300) @(posedge clk_i);
    `CHK(hs_en_o, 1'b0)
    cycle_en;
    wg(1'b1);
    wbx(1'b1, `PFS_REG_POL, 32'h0003_0200);
    @(posedge clk_i) oc_flag_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK(hs_en_o, 1'b1)
    repeat (60) @(posedge clk_i);
    `CHK(hs_en_o, 1'b0)
    wbx(1'b1, `PFS_REG_POL, 32'h0003_0300);
    cycle_en;
    @(posedge clk_i) oc_flag_i <= 1'b0;
    wg(1'b1);
    $display("test current done");
    // temperature: immediate, then endless retry with warning hysteresis
    wbx(1'b1, `PFS_REG_POL, 32'h0003_0000);
    @(posedge clk_i) temp_c_i <= 8'h82;
    wg(1'b0);
    @(posedge clk_i) temp_c_i <= 8'h32;
    wg(1'b1);
    wbx(1'b1, `PFS_REG_POL, 32'h0003_3000);
    @(posedge clk_i) temp_c_i <= 8'h82;
    repeat (10) @(posedge clk_i);
    temp_c_i <= 8'h73;
    repeat (200) @(posedge clk_i);
    `CHK(hs_en_o, 1'b0)
    temp_c_i <= 8'h64;
    wg(1'b1);
    // input lockout: immediate, run on, delayed off
    wbx(1'b1, `PFS_REG_POL, 32'h0003_0000);
    @(posedge clk_i) vin_mv_i <= 16'h07D0;
    wg(1'b0);
    @(posedge clk_i) vin_mv_i <= 16'h2EE0;
    wg(1'b1);
    wbx(1'b1, `PFS_REG_POL, 32'h0003_0001);
    @(posedge clk_i) vin_mv_i <= 16'h07D0;
    repeat (30) @(posedge clk_i);
    `CHK(output_good_flag_o, 1'b1)
    wbx(1'b1, `PFS_REG_POL, 32'h0003_0002);
    repeat (100) @(posedge clk_i);
    vin_mv_i <= 16'h2EE0;
    repeat (50) @(posedge clk_i);
    `CHK(hs_en_o, 1'b0)
    cycle_en;
    wg(1'b1);
    $display("test faults done");
    print_verdict;
  end
endmodule
